/* File: include/serdes_tx_pkg.sv */
package serdes_tx_pkg;
  // ==========================================================
  // geometry
  localparam int NUM_CH = 8;
  localparam int NUM_PAIR = 4;
  localparam int WORD_W = 10;
  localparam int NIB_W = 5;
  localparam int K_BIT = 8;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;
  // ==========================================================
  // management register map
  localparam logic [4:0] MGMT_CTRL_ADDR = 5'h11;
  localparam logic [4:0] SOFT_RST_ADDR = 5'h12;
  localparam logic [4:0] STATUS_ADDR = 5'h13;
  localparam int IFACE_OVR_BIT = 6;
  localparam int ENC_EN_BIT = 7;
  localparam int CLK_SEL_BIT = 15;
  localparam logic [15:0] MGMT_CTRL_RST = 16'h0000;
  localparam logic [7:0] SOFT_RST_RST = 8'h00;
  // ==========================================================
  // timing: core clock stands in for the bit clock
  localparam int REF_PERIOD_NS = 10;
  localparam int BIT_PERIOD_NS = REF_PERIOD_NS / WORD_W;
  localparam logic [1:0] FULL_BIT_CYCLES = 2'h1;
  localparam logic [1:0] HALF_BIT_CYCLES = 2'h2;
  localparam logic [3:0] LAST_BIT = 4'h9;
  localparam logic [3:0] BYTE_CLK_HALF = 4'h5;
  // ==========================================================
  // encoder constants
  localparam logic [9:0] INVALID_K_CODE = 10'h3e0;
  localparam logic [5:0] K28_6B = 6'h0f;
  localparam logic [3:0] ALT7_4B = 4'h7;
  // ==========================================================
  // carriers
  typedef struct packed {
    logic nibble;
    logic half_rate;
    logic independent;
    logic encode;
  } tx_mode_t;
  typedef struct packed {
    logic interface_sel;
    logic rate_sel;
    logic clocking_sel;
    logic encode_sel;
  } mode_pins_t;
endpackage

/* File: sim/mac_source_model.sv */
`timescale 1ns/1ns
// ==========================================================
// protocol-side source: pair clocks and DDR bus
module mac_source_model
  import serdes_tx_pkg::*;
(
  input wire logic core_clk_i,                    // core clock
  input wire logic resetn_i,                      // reset, low
  input wire logic run_i,                         // clocks running
  input wire logic half_i,                        // half rate clock
  input wire logic nibble_i,                      // nibble framing
  input wire logic stop_others_i,                 // only pair A/B clock runs
  input wire logic [WORD_W-1:0] word_a_i,         // word for A, C, E, G
  input wire logic [WORD_W-1:0] word_b_i,         // word for B, D, F, H
  output logic [NUM_PAIR-1:0] pair_clk_o,         // pair clocks, bit 0 = A/B
  output logic [NUM_PAIR*WORD_W-1:0] bus_o        // four copies of the bus
);
  logic [4:0] cnt = 5'h00;
  logic clk_q = 1'b0;
  logic [WORD_W-1:0] lane_q = '0;
  // one clock period per word: 10 core cycles, 20 at half rate
  wire [4:0] last = half_i ? 5'h09 : 5'h04;
  // rising edge takes B or low nibbles, falling edge A or high nibbles
  wire [WORD_W-1:0] mux_w = clk_q ? word_a_i : word_b_i;
  wire [WORD_W-1:0] nib_w = clk_q ? {word_b_i[9:5], word_a_i[9:5]}
                                  : {word_b_i[4:0], word_a_i[4:0]};
  wire [WORD_W-1:0] next_lane = nibble_i ? nib_w : mux_w;
  // data moves two cycles into each phase so it is settled around every edge
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt <= 5'h00;
      clk_q <= 1'b0;
      lane_q <= '0;
    end else if (!run_i) begin
      cnt <= 5'h00;
      clk_q <= 1'b0;
      lane_q <= ~lane_q; // idle bus never repeats its last value
    end else begin
      cnt <= (cnt >= last) ? 5'h00 : cnt + 5'h01;
      if (cnt >= last) clk_q <= ~clk_q;
      if (cnt == 5'h02) lane_q <= next_lane;
    end
  end
  assign pair_clk_o = {{3{clk_q & !stop_others_i}}, clk_q};
  assign bus_o = {NUM_PAIR{lane_q}};
endmodule

/* File: sim/serdes_tx_checker.sv */
`timescale 1ns/1ns
// ==========================================================
// port checker for the transmit path
module serdes_tx_checker
  import serdes_tx_pkg::*;
(
  input wire logic core_clk_i,                // clock
  input wire logic resetn_i,                  // reset, low
  input wire logic [ADDR_W-1:0] reg_addr_i,   // address
  input wire logic [DATA_W-1:0] reg_wdata_i,  // write data
  input wire logic reg_write_i,               // write strobe
  input wire logic reg_read_i,                // read strobe
  input wire logic [DATA_W-1:0] reg_rdata_o,  // read data
  input wire logic [NUM_CH-1:0] tx_serial_o,  // serial lines
  input wire logic byte_clock_o               // byte clock
);
  logic [DATA_W-1:0] ctrl_sh;
  logic [7:0] srst_sh;
  logic [5:0] wr_age;
  logic [3:0] bclk_age;
  // only the three mode bits are compared, the rest may read as zero
  wire [DATA_W-1:0] ctrl_mask = 16'h80c0;
  wire is_ctrl = reg_addr_i == MGMT_CTRL_ADDR;
  wire is_srst = reg_addr_i == SOFT_RST_ADDR;
  wire is_stat = reg_addr_i == STATUS_ADDR;
  wire [3:0] want = {ctrl_sh[IFACE_OVR_BIT], 1'b0, ctrl_sh[CLK_SEL_BIT], ctrl_sh[ENC_EN_BIT]};
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  // shadows of software writes and ages since the last change
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_sh <= MGMT_CTRL_RST;
      srst_sh <= SOFT_RST_RST;
      wr_age <= 6'h00;
      bclk_age <= 4'h0;
    end else begin
      if (reg_write_i && is_ctrl) ctrl_sh <= reg_wdata_i;
      if (reg_write_i && is_srst) srst_sh <= reg_wdata_i[7:0];
      wr_age <= reg_write_i ? 6'h00 : wr_age + {5'h00, wr_age != 6'h3f};
      bclk_age <= $changed(byte_clock_o) ? 4'h0 : bclk_age + {3'h0, bclk_age != 4'hf};
    end
  end
  // ==========================================================
  // assertions
  rdata_idle_a: assert property (!$past(reg_read_i) |-> reg_rdata_o == '0)
    else $error("read data outside the read slot");
  ctrl_readback_a: assert property (reg_read_i && is_ctrl |=>
    (reg_rdata_o & ctrl_mask) == (ctrl_sh & ctrl_mask)) else $error("control readback wrong");
  srst_readback_a: assert property (reg_read_i && is_srst |=> reg_rdata_o[7:0] == srst_sh)
    else $error("soft reset readback wrong");
  unmapped_read_a: assert property (reg_read_i && !(is_ctrl || is_srst || is_stat)
    |=> reg_rdata_o == '0) else $error("unmapped read not zero");
  status_mode_a: assert property (reg_read_i && is_stat && wr_age > 6'h04
    |=> (reg_rdata_o[3:0] & want) == want) else $error("status misses a forced mode");
  pair_silenced_a: assert property (srst_sh[0] && wr_age > 6'h28
    |-> tx_serial_o[1:0] == 2'b00) else $error("pair A/B sends during soft reset");
  byte_clk_hold_a: assert property ($changed(byte_clock_o)
    |=> $stable(byte_clock_o)[*4]) else $error("byte clock phase too short");
  byte_clk_run_a: assert property (bclk_age < 4'hb)
    else $error("byte clock phase too long");
  cover property (reg_read_i && is_stat);
  cover property (srst_sh[0] && wr_age > 6'h28);
  cover property ($rose(byte_clock_o));
endmodule

bind octal_serdes_transmit_path serdes_tx_checker serdes_tx_checker_inst (
  .core_clk_i, .resetn_i, .reg_addr_i, .reg_wdata_i, .reg_write_i, .reg_read_i,
  .reg_rdata_o, .tx_serial_o, .byte_clock_o);

/* File: sim/tb_octal_serdes_transmit_path.sv */
`timescale 1ns/1ns
module tb_octal_serdes_transmit_path;
  import serdes_tx_pkg::*;
  logic core_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  mode_pins_t pins = '0;
  logic nib = 1'b0;
  logic run = 1'b0;
  logic stop = 1'b0;
  logic [3:0] pair_clk;
  logic [NUM_PAIR*WORD_W-1:0] bus;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [DATA_W-1:0] rdata;
  logic [NUM_CH-1:0] ser;
  logic [9:0] w_a = '0;
  logic [9:0] w_b = '0;
  logic [29:0] cap [NUM_CH];
  logic [2:0] tbl [5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h3};
  logic [31:0] seed = 32'hc284;
  int bad_count = 0;
  int cmp_count = 0;
  // ==========================================================
  // design, far side and clock
  octal_serdes_transmit_path octal_serdes_transmit_path_inst (
    .core_clk_i(core_clk_i), .resetn_i(resetn_i), .mode_pin_zero_i(pins.interface_sel),
    .mode_pin_one_i(pins.rate_sel), .tx_clocking_select_i(pins.clocking_sel),
    .encoding_enable_i(pins.encode_sel), .tx_clock_pair_ab_i(pair_clk[0]),
    .tx_clock_pair_cd_i(pair_clk[1]), .tx_clock_pair_ef_i(pair_clk[2]),
    .tx_clock_pair_gh_i(pair_clk[3]), .tx_parallel_bus_i(bus), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_write_i(wr), .reg_read_i(rd), .reg_rdata_o(rdata),
    .tx_serial_o(ser), .byte_clock_o());
  mac_source_model mac_source_model_inst (
    .core_clk_i(core_clk_i), .resetn_i(resetn_i), .run_i(run), .half_i(pins.rate_sel),
    .nibble_i(nib), .stop_others_i(stop), .word_a_i(w_a), .word_b_i(w_b),
    .pair_clk_o(pair_clk), .bus_o(bus));
  initial begin
    forever #5 core_clk_i = ~core_clk_i;
  end
  // ==========================================================
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // code constants are written msb first, the line sends bit 0 first
  function automatic logic [9:0] rev10(input logic [9:0] v);
    for (int i = 0; i < 10; i++) rev10[i] = v[9-i];
  endfunction
  // any 10-bit stretch of the capture starting at bit 0 to 19, masked, equals the pattern
  function automatic logic seen(input logic [29:0] b, input logic [9:0] p, input logic [9:0] m);
    seen = 1'b0;
    for (int r = 0; r < 20; r++) begin
      if ((b[r+:10] & m) === p) seen = 1'b1;
    end
  endfunction
  task automatic check(input logic ok, input string what);
    cmp_count++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask
  task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge core_clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk_i);
    wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] m,
                        input logic [DATA_W-1:0] e);
    @(posedge core_clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk_i);
    rd <= 1'b0;
    #1;
    check((rdata & m) === e, "register read value");
  endtask
  // settle, then take 30 bit times from every line
  task automatic grab(input int step);
    repeat (40 * step) @(posedge core_clk_i);
    for (int i = 0; i < 30; i++) begin
      repeat (step) @(posedge core_clk_i);
      #1;
      for (int c = 0; c < NUM_CH; c++) cap[c][i] = ser[c];
    end
  endtask
  // random raw words; held pairs must keep the previous ones
  task automatic traffic(input int step, input logic held);
    logic [9:0] old_a;
    logic [9:0] old_b;
    old_a = w_a;
    old_b = w_b;
    seed = lfsr(seed);
    @(posedge core_clk_i);
    w_a <= seed[9:0];
    w_b <= seed[19:10];
    grab(step);
    for (int c = 0; c < NUM_CH; c++) begin
      check(seen(cap[c], (held && c > 1) ? (c[0] ? old_b : old_a) : (c[0] ? w_b : w_a),
        10'h3ff), "serial word");
    end
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ==========================================================
  // watchdog and main sequence
  initial begin
    repeat (30000) @(posedge core_clk_i);
    bad_count++;
    test_done();
  end
  initial begin
    repeat (8) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    reg_rd(MGMT_CTRL_ADDR, 16'hffff, MGMT_CTRL_RST);
    reg_rd(SOFT_RST_ADDR, 16'hffff, 16'h0000);
    reg_rd(5'h05, 16'hffff, 16'h0000);
    run <= 1'b1;
    // table rows: {override, interface pin, rate pin}
    for (int i = 0; i < 5; i++) begin
      reg_wr(MGMT_CTRL_ADDR, {9'h000, tbl[i][2], 6'h00});
      pins.interface_sel <= tbl[i][1];
      pins.rate_sel <= tbl[i][0];
      nib <= tbl[i][2] | tbl[i][1];
      traffic(tbl[i][0] ? 2 : 1, 1'b0);
      reg_rd(STATUS_ADDR, 16'h000f, {12'h000, tbl[i][2] | tbl[i][1], tbl[i][0], 2'h0});
    end
    pins <= '0;
    nib <= 1'b0;
    // encode by pin, then by control bit: comma, then an invalid control code
    for (int i = 0; i < 2; i++) begin
      reg_wr(MGMT_CTRL_ADDR, {8'h00, i[0], 7'h00});
      pins.encode_sel <= !i[0];
      w_a <= 10'h1bc;
      w_b <= 10'h1bc;
      grab(1);
      check(seen(cap[0], 10'h07c, 10'h07f) && seen(cap[0], 10'h003, 10'h07f) &&
        seen(cap[7], 10'h07c, 10'h07f) && seen(cap[7], 10'h003, 10'h07f), "comma");
      reg_rd(STATUS_ADDR, 16'h0001, 16'h0001);
      w_a <= 10'h100;
      grab(1);
      check(seen(cap[2], rev10(INVALID_K_CODE), 10'h3ff), "invalid control code");
    end
    reg_wr(MGMT_CTRL_ADDR, 16'h0000);
    pins.encode_sel <= 1'b0;
    // only pair A/B clock runs: sync, register, sync, pin
    stop <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      reg_wr(MGMT_CTRL_ADDR, (i == 1) ? 16'h8000 : 16'h0000);
      pins.clocking_sel <= i == 3;
      traffic(1, i[0]);
    end
    stop <= 1'b0;
    pins.clocking_sel <= 1'b0;
    // soft reset on A silences its partner too, then the partner returns
    w_a <= 10'h001;
    w_b <= 10'h3fe;
    reg_wr(SOFT_RST_ADDR, 16'h0001);
    grab(1);
    check(cap[0] === '0 && cap[1] === '0 && seen(cap[2], 10'h001, 10'h3ff), "pair reset");
    reg_rd(SOFT_RST_ADDR, 16'h00ff, 16'h0001);
    reg_wr(SOFT_RST_ADDR, 16'h0000);
    grab(1);
    check(seen(cap[1], 10'h3fe, 10'h3ff), "partner back");
    test_done();
  end
endmodule

/* File: src/enc_8b10b.sv */
`timescale 1ns/1ns
module enc_8b10b
  import serdes_tx_pkg::*;
(
  input wire logic core_clk_i,          // core clock
  input wire logic resetn_i,            // async reset, low
  input wire logic soft_rst_i,          // channel soft reset
  input wire logic advance_i,           // word consumed
  input wire logic [7:0] data_i,        // character
  input wire logic k_i,                 // control character
  output logic [WORD_W-1:0] code_o      // code, bit 0 sent first
);
  // ==========================================================
  // code tables, abcdei / fghj written msb first, negative rd
  localparam logic [5:0] T6 [32] = '{
    6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
    6'h39, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h17,
    6'h1b, 6'h23, 6'h13, 6'h32, 6'h0b, 6'h2a, 6'h1a, 6'h3a,
    6'h33, 6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b};
  localparam logic [3:0] T4 [8] = '{
    4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha, 4'h6, 4'he};
  logic rd;
  logic rd_mid;
  logic next_rd;
  logic [4:0] x;
  logic [2:0] y;
  logic k28, kx7, alt7, unbal6, unbal4;
  logic [5:0] b6, c6;
  logic [3:0] b4, c4;
  logic [9:0] msb;
  // ==========================================================
  // disparity-driven choice of each sub-block variant
  always_comb begin
    x = data_i[4:0];
    y = data_i[7:5];
    k28 = k_i && (x == 5'd28);
    kx7 = k_i && (y == 3'd7) && (x == 5'd23 || x == 5'd27 || x == 5'd29 || x == 5'd30);
    b6 = k28 ? K28_6B : T6[x];
    unbal6 = ($countones(b6) != 3);
    c6 = ((unbal6 || (x == 5'd7 && !k28)) && rd) ? ~b6 : b6;
    rd_mid = unbal6 ? ~rd : rd;
    alt7 = (y == 3'd7) && (kx7 || (!rd_mid && (x == 5'd17 || x == 5'd18 || x == 5'd20))
           || (rd_mid && (x == 5'd11 || x == 5'd13 || x == 5'd14)));
    b4 = alt7 ? ALT7_4B : T4[y];
    unbal4 = ($countones(b4) != 2);
    if (k28 && !unbal4 && y != 3'd3) begin
      c4 = rd_mid ? b4 : ~b4;
    end else begin
      c4 = ((unbal4 || y == 3'd3) && rd_mid) ? ~b4 : b4;
    end
    next_rd = unbal4 ? ~rd_mid : rd_mid;
    msb = {c6, c4};
    if (k_i && !(k28 || kx7)) begin
      msb = INVALID_K_CODE;
      next_rd = rd;
    end
    for (int i = 0; i < WORD_W; i++) begin
      code_o[i] = msb[WORD_W-1-i];
    end
  end
  // running disparity, negative after reset
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rd <= 1'b0;
    end else if (soft_rst_i) begin
      rd <= 1'b0;
    end else if (advance_i) begin
      rd <= next_rd;
    end
  end
endmodule

/* File: src/octal_serdes_transmit_path.sv */
// Design decisions made here: the placing of the registers and the strobed register port.
`timescale 1ns/1ns
// Summary of operation
// - interface pin low selects multiplexed pairs, high nibble; override bit 17.6 can force.
// - synchronous clocking only if clocking pin and bit 17.15 are both low.
// - rate pin high gives half rate, low gives full rate.
// - input holding stage absorbs phase offset; half rate reads at half speed.
// - byte clock runs at one tenth of the data rate.
// - each channel takes 8 bits plus K, or a raw 10-bit word.
// - synchronous mode captures every pair on both edges of the first pair clock.
// - independent mode times each pair from its own clock.
// - multiplexed: pair shares a bus, B on rising, A on falling edge.
// - nibble: B from bits 9 to 5, A from bits 4 to 0.
// - soft reset on A, C, E or G corrupts partner data while held.
// - encoder picks code variants keeping running disparity balanced.
// - bus bit 8 with data requests a K-character; receiver flags it.
// - all twelve K-characters sent; other K requests send an invalid code.
// - each serializer loads a 10-bit word and sends lsb first.
// - encoding enabled when encode pin or bit 17.7 is high.
module octal_serdes_transmit_path
  import serdes_tx_pkg::*;
(
  input wire logic core_clk_i,                         // core clock
  input wire logic resetn_i,                           // async reset, low
  input wire logic mode_pin_zero_i,                    // interface select pin
  input wire logic mode_pin_one_i,                     // rate select pin
  input wire logic tx_clocking_select_i,               // clocking mode pin
  input wire logic encoding_enable_i,                  // encode pin
  input wire logic tx_clock_pair_ab_i,                 // pair A/B clock
  input wire logic tx_clock_pair_cd_i,                 // pair C/D clock
  input wire logic tx_clock_pair_ef_i,                 // pair E/F clock
  input wire logic tx_clock_pair_gh_i,                 // pair G/H clock
  input wire logic [NUM_PAIR*WORD_W-1:0] tx_parallel_bus_i, // four 10-bit buses
  input wire logic [ADDR_W-1:0] reg_addr_i,            // register address
  input wire logic [DATA_W-1:0] reg_wdata_i,           // write data
  input wire logic reg_write_i,                        // write strobe
  input wire logic reg_read_i,                         // read strobe
  output logic [DATA_W-1:0] reg_rdata_o,               // read data, next cycle
  output logic [NUM_CH-1:0] tx_serial_o,               // serial out, bit i = channel
  output logic byte_clock_o                            // byte clock out
);
  localparam int SYNC_W = 4 + NUM_PAIR + NUM_PAIR * WORD_W;

  // ==========================================================
  // pin synchronisers
  logic [SYNC_W-1:0] sync_a;
  logic [SYNC_W-1:0] sync_b;
  logic [SYNC_W-1:0] raw_pins;
  mode_pins_t pins;
  logic [NUM_PAIR-1:0] pclk;
  logic [NUM_PAIR-1:0] pclk_prev;
  logic [NUM_PAIR*WORD_W-1:0] bus;

  assign raw_pins = {mode_pin_zero_i, mode_pin_one_i, tx_clocking_select_i,
                     encoding_enable_i, tx_clock_pair_gh_i, tx_clock_pair_ef_i,
                     tx_clock_pair_cd_i, tx_clock_pair_ab_i, tx_parallel_bus_i};

  // two stages, clocks and data ride together so edges line up
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= raw_pins;
      sync_b <= sync_a;
    end
  end

  assign pins = mode_pins_t'(sync_b[SYNC_W-1 -: 4]);
  assign pclk = sync_b[NUM_PAIR*WORD_W +: NUM_PAIR];
  assign bus = sync_b[NUM_PAIR*WORD_W-1:0];

  // previous clock level for edge detection
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pclk_prev <= '0;
    end else begin
      pclk_prev <= pclk;
    end
  end

  // ==========================================================
  // management registers
  logic [DATA_W-1:0] mgmt_ctrl;
  logic [NUM_CH-1:0] soft_rst;
  logic [DATA_W-1:0] next_rdata;
  logic hit_ctrl;
  logic hit_srst;
  logic hit_stat;
  tx_mode_t mode;

  // address decode
  assign hit_ctrl = (reg_addr_i == MGMT_CTRL_ADDR);
  assign hit_srst = (reg_addr_i == SOFT_RST_ADDR);
  assign hit_stat = (reg_addr_i == STATUS_ADDR);

  // writes
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mgmt_ctrl <= MGMT_CTRL_RST;
      soft_rst <= SOFT_RST_RST;
    end else if (reg_write_i) begin
      if (hit_ctrl) begin
        mgmt_ctrl <= reg_wdata_i;
      end else if (hit_srst) begin
        soft_rst <= reg_wdata_i[NUM_CH-1:0];
      end
    end
  end

  // read mux, unmapped addresses read zero
  always_comb begin
    if (!reg_read_i) begin
      next_rdata = '0;
    end else if (hit_ctrl) begin
      next_rdata = mgmt_ctrl;
    end else if (hit_srst) begin
      next_rdata = {{(DATA_W-NUM_CH){1'b0}}, soft_rst};
    end else if (hit_stat) begin
      next_rdata = {{(DATA_W-4){1'b0}}, mode};
    end else begin
      next_rdata = '0;
    end
  end

  // data stand only in the cycle after the strobe
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reg_rdata_o <= '0;
    end else begin
      reg_rdata_o <= next_rdata;
    end
  end

  // ==========================================================
  // mode resolution
  // override can only force nibble mode, never force multiplexed
  assign mode.nibble = pins.interface_sel | mgmt_ctrl[IFACE_OVR_BIT];
  assign mode.independent = pins.clocking_sel | mgmt_ctrl[CLK_SEL_BIT];
  assign mode.half_rate = pins.rate_sel;
  assign mode.encode = pins.encode_sel | mgmt_ctrl[ENC_EN_BIT];

  // ==========================================================
  // bit and word timing against the reference clock
  logic [1:0] bit_div;
  logic [1:0] bit_len;
  logic [3:0] bit_cnt;
  logic [3:0] bclk_cnt;
  logic bit_tick;
  logic word_load;
  logic byte_clock;

  // half rate stretches every bit over two core cycles
  assign bit_len = mode.half_rate ? HALF_BIT_CYCLES : FULL_BIT_CYCLES;
  assign bit_tick = (bit_div == bit_len - 2'h1);
  assign word_load = bit_tick && (bit_cnt == LAST_BIT);

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bit_div <= '0;
    end else if (bit_tick) begin
      bit_div <= '0;
    end else begin
      bit_div <= bit_div + 2'h1;
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bit_cnt <= '0;
    end else if (word_load) begin
      bit_cnt <= '0;
    end else if (bit_tick) begin
      bit_cnt <= bit_cnt + 4'h1;
    end
  end

  // byte clock: one period per word time
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bclk_cnt <= '0;
      byte_clock <= 1'b0;
    end else if (bit_tick && bclk_cnt == BYTE_CLK_HALF - 4'h1) begin
      bclk_cnt <= '0;
      byte_clock <= ~byte_clock;
    end else if (bit_tick) begin
      bclk_cnt <= bclk_cnt + 4'h1;
    end
  end

  assign byte_clock_o = byte_clock;

  // ==========================================================
  // per-pair DDR capture and holding stage
  logic [NUM_CH*WORD_W-1:0] held;

  genvar p;
  generate
    for (p = 0; p < NUM_PAIR; p++) begin : g_pair
      logic clk_now;
      logic clk_old;
      logic rise;
      logic fall;
      logic pair_rst;
      logic [WORD_W-1:0] pbus;
      logic [NIB_W-1:0] lo_a;
      logic [NIB_W-1:0] lo_b;
      logic [WORD_W-1:0] word_a;
      logic [WORD_W-1:0] word_b;

      // synchronous mode runs every pair from the first pair clock
      assign clk_now = mode.independent ? pclk[p] : pclk[0];
      assign clk_old = mode.independent ? pclk_prev[p] : pclk_prev[0];
      assign rise = clk_now & ~clk_old;
      assign fall = ~clk_now & clk_old;
      assign pbus = bus[p*WORD_W +: WORD_W];
      // shared input bank: the A-side reset wipes the partner too
      assign pair_rst = soft_rst[2*p];

      always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          lo_a <= '0;
          lo_b <= '0;
          word_a <= '0;
          word_b <= '0;
        end else if (pair_rst) begin
          lo_a <= '0;
          lo_b <= '0;
          word_a <= '0;
          word_b <= '0;
        end else if (!mode.nibble) begin
          if (rise) begin
            word_b <= pbus;
          end
          if (fall) begin
            word_a <= pbus;
          end
        end else begin
          if (rise) begin
            lo_b <= pbus[WORD_W-1:NIB_W];
            lo_a <= pbus[NIB_W-1:0];
          end
          if (fall) begin
            word_b <= {pbus[WORD_W-1:NIB_W], lo_b};
            word_a <= {pbus[NIB_W-1:0], lo_a};
          end
        end
      end

      assign held[(2*p)*WORD_W +: WORD_W] = word_a;
      assign held[(2*p+1)*WORD_W +: WORD_W] = word_b;
    end
  endgenerate

  // ==========================================================
  // per-channel encoder and serializer
  genvar c;
  generate
    for (c = 0; c < NUM_CH; c++) begin : g_ch
      logic [WORD_W-1:0] in_word;
      logic [WORD_W-1:0] code;
      logic [WORD_W-1:0] load_word;
      logic ser_out;

      assign in_word = held[c*WORD_W +: WORD_W];

      enc_8b10b u_enc (
        .core_clk_i(core_clk_i),
        .resetn_i(resetn_i),
        .soft_rst_i(soft_rst[c]),
        .advance_i(word_load & mode.encode),
        .data_i(in_word[7:0]),
        .k_i(in_word[K_BIT]),
        .code_o(code)
      );

      // reset channel sends zeros; raw mode bypasses the encoder
      assign load_word = soft_rst[c] ? '0 : (mode.encode ? code : in_word);
      tx_serializer u_ser (
        .core_clk_i(core_clk_i),
        .resetn_i(resetn_i),
        .load_i(word_load),
        .shift_i(bit_tick),
        .word_i(load_word),
        .serial_o(ser_out)
      );

      assign tx_serial_o[c] = ser_out;
    end
  endgenerate

endmodule

/* File: src/tx_serializer.sv */
`timescale 1ns/1ns
module tx_serializer
  import serdes_tx_pkg::*;
(
  input wire logic core_clk_i,          // core clock
  input wire logic resetn_i,            // async reset, low
  input wire logic load_i,              // take a new word
  input wire logic shift_i,             // bit period boundary
  input wire logic [WORD_W-1:0] word_i, // word to send
  output logic serial_o                 // serial line
);
  logic [WORD_W-1:0] sreg;
  // ==========================================================
  // lsb leaves first; load replaces the shift at word end
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sreg <= '0;
    end else if (load_i) begin
      sreg <= word_i;
    end else if (shift_i) begin
      sreg <= {1'b0, sreg[WORD_W-1:1]};
    end
  end
  assign serial_o = sreg[0];
endmodule
